// ### pkg/adc_ctrl_pkg.sv
/*
  Shared constants and types for the converter serial control block:
  control byte layout, acquisition mode codes, edge counts and timing.
  Assumes a 100 MHz core clock; every user names items as adc_ctrl_pkg::name.
*/
package adc_ctrl_pkg;
  // Control byte layout, bit 7 is the start bit
  localparam int CTRL_BITS = 8;
  localparam int BIT_START = 7;
  localparam int BIT_POLARITY = 6;
  localparam int BIT_CLK_SRC = 5;
  localparam int BIT_MODE_HI = 4;
  localparam int BIT_MODE_LO = 3;
  localparam int BIT_GP2 = 2;
  localparam int BIT_GP1 = 1;
  localparam int BIT_GP0 = 0;
  // Mode field codes
  localparam logic [1:0] MODE_SHORT = 2'h0;
  localparam logic [1:0] MODE_CAL = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;
  localparam logic [1:0] MODE_LONG = 2'h3;
  // Receive counts: conversion starts after bit 7, byte ends at bit 8
  localparam logic [3:0] BITS_AT_START = 4'h7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Falling serial clock counts after the start bit, external clock
  localparam logic [5:0] EXT_SHORT_STROBE = 6'h07;
  localparam logic [5:0] EXT_LONG_STROBE = 6'h0f;
  localparam logic [5:0] EXT_SHORT_TOTAL = 6'h18;
  localparam logic [5:0] EXT_LONG_TOTAL = 6'h20;
  // Result word
  localparam int RESULT_BITS = 14;
  localparam logic [4:0] RESULT_LEN = 5'h0e;
  // Internal conversion time, a longest time, so it rounds down
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_MAX_NS = 7000;
  localparam int CONV_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
  // Cycles from the timer match to the strobe rise: flag, push, store, load
  localparam int INT_DONE_LAG = 4;
  localparam int CAL_CYCLES_DEFAULT = 80000;
  localparam int TIMER_W = 17;
  // Reset values: bipolar, internal clock, outputs low
  localparam logic RESET_CLK_INT = 1'b1;
  localparam logic RESET_UNIPOLAR = 1'b0;
  localparam logic [2:0] GP_RESET = 3'h0;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_HUNT = 3'b000,
    ST_RECV = 3'b001,
    ST_EXT_CONV = 3'b010,
    ST_INT_CONV = 3'b011,
    ST_CAL = 3'b100,
    ST_PDOWN = 3'b101
  } op_state_t;
endpackage

// ### pkg/stream_if.sv
/*
  Valid/ready word channel between the sequencer and the result buffer.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 14);
  logic valid; // Word offered
  logic ready; // Word can be taken
  logic [WIDTH-1:0] data; // Word itself
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hw/pin_sync.sv
/*
  Two-flop synchronisers for pins plus edge flags on the synchronised level.
  Assumes pins are asynchronous to core_clk; edge flags last one core cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta; // First stage, read only by the second
  logic [W-1:0] prev; // Last level, for edge finding

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_sync
      // Two-stage capture and one history stage per pin
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          meta[i] <= RST_VAL[i];
          level[i] <= RST_VAL[i];
          prev[i] <= RST_VAL[i];
        end else begin
          meta[i] <= pin[i];
          level[i] <= meta[i];
          prev[i] <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev[i];
      assign fall[i] = ~level[i] & prev[i];
    end
  endgenerate
endmodule
`default_nettype wire

// ### hw/result_buffer.sv
/*
  Small result FIFO with valid/ready on both sides.
  Assumes one core clock; ready drops when full, valid drops when empty.
*/
`timescale 1ns/1ns
`default_nettype none
module result_buffer #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  stream_if.snk fill,
  stream_if.src drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage slots
  logic [PW-1:0] wr_ptr; // Next slot to fill
  logic [PW-1:0] rd_ptr; // Oldest slot
  logic [PW:0] count; // Words held
  wire do_wr = fill.valid && fill.ready;
  wire do_rd = drain.valid && drain.ready;

  assign fill.ready = (count != FULL_COUNT);
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];

  // Pointer and occupancy tracking
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
    end
  end

  // Word storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (do_wr) mem[wr_ptr] <= fill.data;
  end
endmodule
`default_nettype wire

// ### hw/adc_serial_control.sv
/*
  Serial control and readout sequencer of a 14-bit successive-approximation
  converter: control byte capture, start detection, conversion strobe,
  calibration and power-down sequencing, result shifting, port outputs.
  Assumes serial pins are asynchronous and much slower than core_clk, and
  that conv_code is the converter core's offset-binary word on core_clk.
*/
// Functional notes
// - Port outputs follow control bits 2..0 together
// - Port outputs zero on reset, held in shutdown
// - Low shutdown pin suspends all conversion
// - Low reset returns every state to power-on
// - Data input sampled on rising serial edges
// - Leading zeros ignored, first one is MSB
// - Result changes on falling edges, floats when deselected
// - Bytes accepted only with chip select low
// - Select pulse re-arms start, new start aborts
// - Bit 5 picks conversion clock source
// - Bit 6 polarity applies to its conversion
// - Short external: strobe after fall 7, MSB fall 8
// - Long external: strobe after fall 15, MSB fall 16
// - External strobe rests low, floats when deselected
// - External conversion pauses while chip select high
// - Internal strobe low during conversion, max 7us
// - Internal result stored, MSB at strobe rise
// - Internal strobe always driven
// - Unipolar straight binary, bipolar two's complement, MSB first
// - Conversion starts on fall after seventh bit
// - Clock source one internal, zero external
// - Mode codes short, calibrate, power-down, long
// - Polarity one unipolar, zero bipolar
// - Calibration strobe sense depends on clock mode
`timescale 1ns/1ns
`default_nettype none
module adc_serial_control #(
  parameter int CAL_CYCLES = adc_ctrl_pkg::CAL_CYCLES_DEFAULT,
  parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES,
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic shutdown_n,
  input wire logic [adc_ctrl_pkg::RESULT_BITS-1:0] conv_code,
  output logic dout,
  output logic dout_oe,
  output logic conversion_strobe,
  output logic conversion_strobe_oe,
  output logic gp_out_bit0,
  output logic gp_out_bit1,
  output logic gp_out_bit2,
  output logic unipolar_mode,
  output logic powered_down
);
  localparam int RB = adc_ctrl_pkg::RESULT_BITS;
  localparam int TW = adc_ctrl_pkg::TIMER_W;
  // Stop the timer early so the strobe rise, which trails the match by the
  // completion flag, buffer write and readout load, still meets the limit
  localparam logic [TW-1:0] CONV_LAST = TW'(CONV_CYCLES - adc_ctrl_pkg::INT_DONE_LAG);
  localparam logic [TW-1:0] CAL_LAST = TW'(CAL_CYCLES - 1);

  // Picks a control field bit while seven bits are held, bit k at k-1
  function automatic logic ctl_bit(input logic [6:0] held, input int pos);
    ctl_bit = held[pos-1];
  endfunction

  // Maps the core's offset-binary word to the output coding
  function automatic logic [RB-1:0] code_word(input logic [RB-1:0] raw,
                                             input logic uni);
    code_word = uni ? raw : {~raw[RB-1], raw[RB-2:0]};
  endfunction

  // Synchronised pins: index 0 sclk, 1 cs_n, 2 din, 3 shutdown_n
  logic [3:0] pin_level; // Synchronised levels
  logic [3:0] pin_rise; // Rising edge flags
  logic [3:0] pin_fall; // Falling edge flags

  pin_sync #(.W(4), .RST_VAL(4'ha)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin({shutdown_n, din, cs_n, sclk}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  wire cs_low = !pin_level[1]; // Chip selected
  wire cs_fell = pin_fall[1]; // Select just asserted
  wire din_s = pin_level[2]; // Data bit at the rising edge
  wire shutdown_n_on = !pin_level[3]; // Hardware shutdown active
  wire shutdown_n_off = pin_rise[3]; // Shutdown just released
  wire rx_rise = pin_rise[0] && cs_low;
  wire rx_fall = pin_fall[0] && cs_low;

  // Sequencer and receiver state
  adc_ctrl_pkg::op_state_t state; // Operation in progress
  logic hunting; // Looking for a start bit
  logic [3:0] bit_cnt; // Control bits received
  logic [6:0] ctrl; // Control bits so far, MSB first
  logic [5:0] fcnt; // Falling edges since the start bit
  logic [TW-1:0] timer; // Internal conversion and calibration timer
  logic clk_int; // Conversion clock source of the current operation
  logic long_acq; // Long acquisition for the current operation
  logic conv_done; // Internal completion, registered ahead of readout
  logic push; // Result word offered to the buffer
  logic [RB-1:0] push_word; // Word offered
  logic [RB-1:0] sh; // Readout shift register
  logic [4:0] left; // Bits still to shift out

  stream_if #(.WIDTH(RB)) to_buf ();
  stream_if #(.WIDTH(RB)) from_buf ();

  assign to_buf.valid = push;
  assign to_buf.data = push_word;
  assign from_buf.ready = (left == '0);

  result_buffer #(.WIDTH(RB), .DEPTH(BUF_DEPTH)) u_buf (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .fill(to_buf),
    .drain(from_buf)
  );

  // Decoding of the byte in flight and of edge positions
  wire start_bit = rx_rise && hunting && din_s;
  wire next_bit = rx_rise && !hunting && (bit_cnt != '0) &&
                  (bit_cnt != adc_ctrl_pkg::BITS_PER_BYTE);
  wire byte_done = next_bit &&
                   (bit_cnt == adc_ctrl_pkg::BITS_AT_START);
  wire [1:0] mode_now = {ctl_bit(ctrl, adc_ctrl_pkg::BIT_MODE_HI),
                         ctl_bit(ctrl, adc_ctrl_pkg::BIT_MODE_LO)};
  wire start_now = (state == adc_ctrl_pkg::ST_RECV) && rx_fall &&
                   (bit_cnt == adc_ctrl_pkg::BITS_AT_START);
  wire src_int_now = ctl_bit(ctrl, adc_ctrl_pkg::BIT_CLK_SRC);
  wire uni_now = ctl_bit(ctrl, adc_ctrl_pkg::BIT_POLARITY);
  wire is_conv_mode = (mode_now == adc_ctrl_pkg::MODE_SHORT) ||
                      (mode_now == adc_ctrl_pkg::MODE_LONG);
  wire ext_start = start_now && is_conv_mode && !src_int_now;
  wire cur_ext = ext_start || (state == adc_ctrl_pkg::ST_EXT_CONV);
  wire cur_long = start_now ? (mode_now == adc_ctrl_pkg::MODE_LONG) : long_acq;
  wire cur_uni = start_now ? uni_now : unipolar_mode;
  wire [5:0] fcnt_next = fcnt + 6'h01;
  wire [5:0] strobe_edge = cur_long ? adc_ctrl_pkg::EXT_LONG_STROBE
                                    : adc_ctrl_pkg::EXT_SHORT_STROBE;
  wire [5:0] total_edge = cur_long ? adc_ctrl_pkg::EXT_LONG_TOTAL
                                   : adc_ctrl_pkg::EXT_SHORT_TOTAL;
  wire ext_hit = rx_fall && cur_ext && (fcnt_next == strobe_edge);
  wire ext_end = rx_fall && (state == adc_ctrl_pkg::ST_EXT_CONV) &&
                 (fcnt_next == total_edge);
  wire int_finish = (state == adc_ctrl_pkg::ST_INT_CONV) && conv_done &&
                    to_buf.ready;
  wire cal_end = (state == adc_ctrl_pkg::ST_CAL) && (timer == CAL_LAST);
  wire op_end = ext_end || int_finish || cal_end;
  wire shift_fall = clk_int ? pin_fall[0] : rx_fall;
  // Internal result reaches the shifter; the strobe rises with the MSB
  wire int_load = clk_int && from_buf.valid && from_buf.ready;

  // Control byte receiver: start hunt, MSB-first shift, re-arm
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hunting <= 1'b1;
      bit_cnt <= '0;
      ctrl <= '0;
    end else if (shutdown_n_on) begin
      hunting <= 1'b0;
      bit_cnt <= '0;
    end else if (shutdown_n_off || cs_fell || op_end) begin
      // Re-arm outranks a start bit landing in the same cycle
      hunting <= 1'b1;
      bit_cnt <= '0;
    end else if (start_bit) begin
      hunting <= 1'b0;
      ctrl <= 7'h01;
      bit_cnt <= 4'h1;
    end else if (next_bit) begin
      ctrl <= {ctrl[5:0], din_s};
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Port outputs take the three low bits when the byte completes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {gp_out_bit2, gp_out_bit1, gp_out_bit0} <= adc_ctrl_pkg::GP_RESET;
    end else if (byte_done) begin
      gp_out_bit2 <= ctrl[adc_ctrl_pkg::BIT_GP2 - 1];
      gp_out_bit1 <= ctrl[adc_ctrl_pkg::BIT_GP1 - 1];
      gp_out_bit0 <= din_s;
    end
  end

  // Operation sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= adc_ctrl_pkg::ST_HUNT;
      fcnt <= '0;
      timer <= '0;
      clk_int <= adc_ctrl_pkg::RESET_CLK_INT;
      unipolar_mode <= adc_ctrl_pkg::RESET_UNIPOLAR;
      long_acq <= 1'b0;
      conversion_strobe <= 1'b0;
    end else if (shutdown_n_on) begin
      state <= adc_ctrl_pkg::ST_PDOWN;
      if (!clk_int) conversion_strobe <= 1'b0;
    end else if (start_bit) begin
      state <= adc_ctrl_pkg::ST_RECV;
      fcnt <= '0;
      if (!clk_int) conversion_strobe <= 1'b0;
    end else begin
      // Raised before the case, so a new internal start can still lower it
      if (int_load) conversion_strobe <= 1'b1;
      case (state)
        adc_ctrl_pkg::ST_HUNT, adc_ctrl_pkg::ST_PDOWN: begin
          if (shutdown_n_off) state <= adc_ctrl_pkg::ST_HUNT;
        end
        adc_ctrl_pkg::ST_RECV: begin
          if (rx_fall) fcnt <= fcnt_next;
          if (start_now) begin
            clk_int <= src_int_now;
            unipolar_mode <= uni_now;
            long_acq <= (mode_now == adc_ctrl_pkg::MODE_LONG);
            timer <= '0;
            case (mode_now)
              adc_ctrl_pkg::MODE_CAL: begin
                state <= adc_ctrl_pkg::ST_CAL;
                conversion_strobe <= !src_int_now;
              end
              adc_ctrl_pkg::MODE_PDOWN: begin
                state <= adc_ctrl_pkg::ST_PDOWN;
              end
              default: begin
                if (src_int_now) begin
                  state <= adc_ctrl_pkg::ST_INT_CONV;
                  conversion_strobe <= 1'b0;
                end else begin
                  state <= adc_ctrl_pkg::ST_EXT_CONV;
                  conversion_strobe <= ext_hit;
                end
              end
            endcase
          end
        end
        adc_ctrl_pkg::ST_EXT_CONV: begin
          if (rx_fall) begin
            fcnt <= fcnt_next;
            conversion_strobe <= ext_hit;
            if (ext_end) state <= adc_ctrl_pkg::ST_HUNT;
          end
        end
        adc_ctrl_pkg::ST_INT_CONV: begin
          if (!conv_done) timer <= timer + 1'b1;
          if (int_finish) begin
            // Strobe waits for the word to pass the buffer, see int_load
            state <= adc_ctrl_pkg::ST_HUNT;
          end
        end
        adc_ctrl_pkg::ST_CAL: begin
          timer <= timer + 1'b1;
          if (cal_end) begin
            conversion_strobe <= clk_int;
            state <= adc_ctrl_pkg::ST_HUNT;
          end
        end
        default: begin
          state <= adc_ctrl_pkg::ST_HUNT;
        end
      endcase
    end
  end

  // Internal conversion completion flag, one register ahead of readout
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      conv_done <= 1'b0;
    end else if (state != adc_ctrl_pkg::ST_INT_CONV || start_bit || shutdown_n_on) begin
      conv_done <= 1'b0;
    end else if (timer == CONV_LAST) begin
      conv_done <= 1'b1;
    end
  end

  // Result word offered to the buffer at the sampling point
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      push <= 1'b0;
      push_word <= '0;
    end else if (push && !to_buf.ready) begin
      // A refused word is held until the buffer frees a slot
      push <= 1'b1;
    end else begin
      push <= ext_hit || (int_finish && !push);
      push_word <= code_word(conv_code, cur_uni);
    end
  end

  // Readout shifter: MSB first, falling serial edges
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sh <= '0;
      left <= '0;
      dout <= 1'b0;
    end else if (start_bit && !clk_int) begin
      // An aborted external readout must not leak its old bits
      left <= '0;
    end else if (from_buf.valid && from_buf.ready) begin
      if (clk_int) begin
        dout <= from_buf.data[RB-1];
        sh <= {from_buf.data[RB-2:0], 1'b0};
        left <= adc_ctrl_pkg::RESULT_LEN - 5'h01;
      end else begin
        sh <= from_buf.data;
        left <= adc_ctrl_pkg::RESULT_LEN;
      end
    end else if (shift_fall) begin
      dout <= (left != '0) ? sh[RB-1] : 1'b0;
      if (left != '0) begin
        sh <= {sh[RB-2:0], 1'b0};
        left <= left - 5'h01;
      end
    end
  end

  // Pin drivers: data floats when deselected, strobe too but only in external mode
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dout_oe <= 1'b0;
      conversion_strobe_oe <= adc_ctrl_pkg::RESET_CLK_INT;
      powered_down <= 1'b0;
    end else begin
      // Enables lag the select pin by the synchroniser, about three cycles
      dout_oe <= cs_low;
      conversion_strobe_oe <= clk_int || cs_low;
      powered_down <= (state == adc_ctrl_pkg::ST_PDOWN);
    end
  end
endmodule
`default_nettype wire

// ### sim/adc_serial_control_checker.sv
/*
  Port-level checks for the converter serial control block.
  Assumes a 100 MHz core_clk and synchronous active-low rst_b; bound below.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_serial_control_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic shutdown_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic conversion_strobe,
  input wire logic conversion_strobe_oe,
  input wire logic gp_out_bit0,
  input wire logic gp_out_bit1,
  input wire logic gp_out_bit2,
  input wire logic unipolar_mode,
  input wire logic powered_down
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Port outputs as one field
  wire logic [2:0] gp = {gp_out_bit2, gp_out_bit1, gp_out_bit0};
  // Serial clock pin was high, selected, early enough for the synchroniser
  sequence s_rise_seen;
    $past(sclk, 2) && !$past(cs_n, 4);
  endsequence
  // Serial clock pin was low early enough for the synchroniser
  sequence s_fall_seen;
    !$past(sclk, 2);
  endsequence
  a_reset_clear: assert property ($rose(rst_b) |-> gp == 3'h0 && !unipolar_mode)
    else $error("outputs not cleared by reset");
  a_gp_on_rise: assert property ($changed(gp) |-> s_rise_seen)
    else $error("port outputs changed away from a serial rise");
  a_pol_on_fall: assert property ($changed(unipolar_mode) |-> s_fall_seen)
    else $error("polarity changed away from a serial fall");
  a_dout_on_fall: assert property ($changed(dout) && !$rose(conversion_strobe) |-> s_fall_seen)
    else $error("result bit changed away from a serial fall");
  a_dout_float: assert property (cs_n [*6] |-> !dout_oe)
    else $error("result pin driven while deselected");
  a_dout_drive: assert property ((!cs_n) [*6] |-> dout_oe)
    else $error("result pin not driven while selected");
  a_strobe_drive: assert property ((!cs_n) [*6] |-> conversion_strobe_oe)
    else $error("strobe not driven while selected");
  a_shutdown_flag: assert property ((!shutdown_n) [*5] |-> powered_down)
    else $error("shutdown pin did not power down");
  a_shutdown_hold: assert property ((!shutdown_n) [*5] |-> $stable(gp))
    else $error("port outputs moved in shutdown");
endmodule
bind adc_serial_control adc_serial_control_checker i_adc_serial_control_checker (
  .core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .shutdown_n(shutdown_n),
  .dout(dout), .dout_oe(dout_oe), .conversion_strobe(conversion_strobe),
  .conversion_strobe_oe(conversion_strobe_oe), .gp_out_bit0(gp_out_bit0),
  .gp_out_bit1(gp_out_bit1), .gp_out_bit2(gp_out_bit2), .unipolar_mode(unipolar_mode),
  .powered_down(powered_down));
`default_nettype wire

// ### sim/host_serial_model.sv
/*
  Host serial master: frames bytes at a 160 ns serial clock, records result bits.
  Assumes the bench calls frame; all pin changes follow core_clk rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
  input wire logic core_clk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic conversion_strobe,
  output var logic sclk,
  output var logic cs_n,
  output var logic din
);
  logic idle; // Data pin not in use
  logic [39:0] word; // Result pin samples, newest at bit 0
  int strb_first; // First fall index with strobe high
  int strb_cnt; // Falls with strobe high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    idle = 1'b1;
  end
  // Unused data line wanders so no stale level is mistaken for data
  always @(posedge core_clk) if (idle) din <= ~din;
  // Floating result pin reads as z
  function automatic logic smp();
    return dout_oe ? dout : 1'bz;
  endfunction
  // One selected frame of nclk serial clocks, pattern sent MSB first
  task automatic frame(input logic [39:0] pat, input int nclk, input bit stay, input bit pause);
    int i;
    idle = 1'b0;
    strb_first = 0;
    strb_cnt = 0;
    @(posedge core_clk);
    cs_n <= 1'b0;
    din <= 1'b0;
    repeat (8) @(posedge core_clk);
    word = {39'h0, smp()};
    for (i = 0; i < nclk; i++) begin
      din <= pat[39-i];
      repeat (3) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (8) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (5) @(posedge core_clk);
      word = {word[38:0], smp()};
      if (conversion_strobe === 1'b1) begin
        strb_cnt++;
        if (strb_first == 0) strb_first = i + 1;
      end
      // Byte-wise host: deselect and clock twice, these must be ignored
      if (pause && i % 8 == 7) begin
        cs_n <= 1'b1;
        repeat (2) begin
          repeat (8) @(posedge core_clk);
          sclk <= 1'b1;
          repeat (8) @(posedge core_clk);
          sclk <= 1'b0;
        end
        repeat (5) @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge core_clk);
      end
    end
    if (!stay) begin
      cs_n <= 1'b1;
      idle = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ### sim/adc_serial_control_tb.sv
/*
  Self-checking bench for adc_serial_control with a host serial model.
  Assumes shortened calibration and conversion counts set below.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_serial_control_tb;
  localparam int CONV = 40; // Shortened internal conversion
  localparam int CAL = 50; // Shortened calibration
  logic core_clk, rst_b, shutdown_n, sclk, cs_n, din;
  logic [adc_ctrl_pkg::RESULT_BITS-1:0] conv_code, code, expw;
  logic dout, dout_oe, strobe, strobe_oe, gp0, gp1, gp2, uni, pdn, pol;
  logic [7:0] ctl; // Control byte under test
  logic [1:0] md; // Mode field
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int n, lead;
  adc_serial_control #(.CAL_CYCLES(CAL), .CONV_CYCLES(CONV)) i_adc_serial_control (
    .core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .din(din),
    .shutdown_n(shutdown_n), .conv_code(conv_code), .dout(dout), .dout_oe(dout_oe),
    .conversion_strobe(strobe), .conversion_strobe_oe(strobe_oe), .gp_out_bit0(gp0),
    .gp_out_bit1(gp1), .gp_out_bit2(gp2), .unipolar_mode(uni), .powered_down(pdn));
  host_serial_model i_host_serial_model (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe),
    .conversion_strobe(strobe), .sclk(sclk), .cs_n(cs_n), .din(din));
  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Cuts a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a strobe level, n holds the cycles spent
  task automatic wait_strobe(input logic lvl);
    n = 0;
    while (strobe !== lvl && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    shutdown_n = 1'b1;
    conv_code = '0;
    void'($urandom(74681));
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({gp2, gp1, gp0, uni, pdn, strobe_oe}, 32'h1);
    $display("test reset done");
    // Software power-down, then hardware shutdown freezes the ports
    ctl = {3'b100, adc_ctrl_pkg::MODE_PDOWN, 3'($urandom)};
    i_host_serial_model.frame({ctl, 32'h0}, 8, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    chk({pdn, gp2, gp1, gp0}, {1'b1, ctl[2:0]});
    shutdown_n <= 1'b0;
    i_host_serial_model.frame({5'b10000, ~ctl[2:0], 32'h0}, 24, 1'b0, 1'b0);
    chk({pdn, gp2, gp1, gp0}, {1'b1, ctl[2:0]});
    shutdown_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    $display("test power-down done");
    // External short and long conversions, leading zeros, byte-wise host
    for (int k = 0; k < 6; k++) begin
      md = (k % 2) ? adc_ctrl_pkg::MODE_LONG : adc_ctrl_pkg::MODE_SHORT;
      pol = 1'($urandom);
      lead = k % 3;
      code = 14'($urandom);
      conv_code <= code;
      expw = pol ? code : code ^ 14'h2000;
      ctl = {1'b1, pol, 1'b0, md, 3'($urandom)};
      n = (md == adc_ctrl_pkg::MODE_LONG) ? 32 : 24;
      i_host_serial_model.frame({ctl, 32'h0} >> lead, n + lead, 1'b0, k == 3);
      chk(i_host_serial_model.word[16:0], {expw, 3'h0});
      chk(i_host_serial_model.strb_first, n - 17 + lead);
      chk(i_host_serial_model.strb_cnt, 1);
      repeat (5) @(posedge core_clk);
      chk(strobe_oe, 1'b0);
      chk({gp2, gp1, gp0, uni, pdn}, {ctl[2:0], pol, 1'b0});
      $display("test external %0d done", k);
    end
    // Internal conversion, result read later
    code = 14'($urandom);
    conv_code <= code;
    pol = 1'($urandom);
    expw = pol ? code : code ^ 14'h2000;
    ctl = {1'b1, pol, 1'b1, adc_ctrl_pkg::MODE_SHORT, 3'($urandom)};
    i_host_serial_model.frame({ctl, 32'h0}, 8, 1'b0, 1'b0);
    wait_strobe(1'b1);
    chk({n > 0 && n <= CONV, strobe_oe}, 32'h3);
    i_host_serial_model.frame(40'h0, 14, 1'b0, 1'b0);
    chk(i_host_serial_model.word[14:1], expw);
    $display("test internal done");
    // External calibration: strobe high at start, low at end
    ctl = {3'b100, adc_ctrl_pkg::MODE_CAL, 3'h5};
    i_host_serial_model.frame({ctl, 32'h0}, 8, 1'b1, 1'b0);
    chk(strobe, 1'b1);
    wait_strobe(1'b0);
    chk(n <= CAL, 1'b1);
    i_host_serial_model.frame(40'h0, 0, 1'b0, 1'b0);
    $display("test calibration done");
    // Reset in mid-run clears the ports
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk({gp2, gp1, gp0, uni}, 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
